/* design/pll_core.sv */
// synthesizer digital core: serial port, counters, phase detector
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module pll_core
    import pll_ctrl_pkg::*;
(
    input  wire logic  mclk_i,
    input  wire logic  rst_i,
    pll_prog_if.dev    prog,
    input  wire logic  rf_in_i,       // rf input, sampled
    input  wire logic  ref_in_i,      // reference input, sampled
    input  wire logic  pre_sel56_i,   // 1 selects 5/6 modulus
    output logic       pump_up_n_o,
    output logic       pump_down_n_o,
    output logic       lock_filter_o,
    output logic       lock_indicator_o,
    output logic       monitor_o,
    output logic       modulus_control_o
);
    //----------------------------------------------------------------
    // synchronise every outside input
    //----------------------------------------------------------------
    // rf and ref must stay below mclk/4 or edges are lost
    logic sck_s, sdi_s, ldst_s, fws_s, fen_s, par_s, rf_s, ref_s;
    logic        sel56_s;  // modulus select, synced like any pin
    logic [20:0] pin_s;    // parallel setting pins, synced
    sync2 u_s56 (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(pre_sel56_i), .q_o(sel56_s));
    sync2 u_sck (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(prog.shift_clk), .q_o(sck_s));
    sync2 u_sdi (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(prog.serial_bit_in), .q_o(sdi_s));
    sync2 u_lds (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(prog.load_strobe), .q_o(ldst_s));
    sync2 u_fws (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(prog.feat_wr_sel), .q_o(fws_s));
    sync2 u_fen (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(prog.feature_enable_n), .q_o(fen_s));
    sync2 u_par (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(prog.parallel_sel), .q_o(par_s));
    sync2 u_rf  (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(rf_in_i), .q_o(rf_s));
    sync2 u_ref (.mclk_i(mclk_i), .rst_i(rst_i),
                 .d_i(ref_in_i), .q_o(ref_s));
    genvar gi;
    generate
        for (gi = 0; gi < SET_W; gi++) begin : g_pin
            sync2 u_p (.mclk_i(mclk_i), .rst_i(rst_i),
                       .d_i(prog.par_setting[gi]), .q_o(pin_s[gi]));
        end
    endgenerate
    //----------------------------------------------------------------
    // edge detection on synchronised levels
    //----------------------------------------------------------------
    logic sck_d_r, ldst_d_r, fws_d_r, rf_d_r, ref_d_r;
    wire sck_rise  = sck_s & ~sck_d_r;
    wire ldst_rise = ldst_s & ~ldst_d_r;
    wire fws_fall  = ~fws_s & fws_d_r;
    wire rf_rise   = rf_s & ~rf_d_r;
    wire ref_rise  = ref_s & ~ref_d_r;
    // delayed copies reset to the idle low level, so no false edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            {sck_d_r, ldst_d_r, fws_d_r, rf_d_r, ref_d_r} <= 5'h00;
        end else begin
            {sck_d_r, ldst_d_r, fws_d_r, rf_d_r, ref_d_r} <=
                {sck_s, ldst_s, fws_s, rf_s, ref_s};
        end
    end
    //----------------------------------------------------------------
    // serial shift registers, buffers
    //----------------------------------------------------------------
    logic [SET_W-1:0]  set_sh_r;   // primary, b0 ends in bit 20
    logic [SET_W-1:0]  set_act_r;  // secondary
    logic [FEAT_W-1:0] feat_sh_r;  // feature shift, b0 ends in bit 7
    logic [FEAT_W-1:0] feat_act_r; // feature active buffer
    wire shift_set  = sck_rise & ~ldst_s & ~fws_s;
    wire shift_feat = sck_rise & ~ldst_s & fws_s;
    // programming keeps running during power down
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            set_sh_r   <= '0;
            set_act_r  <= '0;
            feat_sh_r  <= '0;
            feat_act_r <= '0;
        end else begin
            if (shift_set)
                set_sh_r <= {set_sh_r[SET_W-2:0], sdi_s};
            if (shift_feat)
                feat_sh_r <= {feat_sh_r[FEAT_W-2:0], sdi_s};
            if (ldst_rise)
                set_act_r <= set_sh_r;
            if (fws_fall)
                feat_act_r <= feat_sh_r;
        end
    end
    //----------------------------------------------------------------
    // setting source and field decode; word bit 20-k holds bk
    //----------------------------------------------------------------
    wire [SET_W-1:0] set_w = par_s ? {pin_s[20:1], 1'b0} : set_act_r;
    wire [REF_W-1:0]  ref_v  = {set_w[20:19], set_w[8:5]};
    wire [MAIN_W-1:0] main_v = {set_w[18:17], set_w[15:9]};
    wire              pre_off = set_w[16];
    wire [SWAL_W-1:0] swal_v = set_w[4:1];
    // feature bit bk sits at word bit 7-k
    wire feat_on = ~fen_s & ~par_s;
    wire f_mmon  = feat_on & feat_act_r[7-FB_MAIN_MON];
    wire f_pdn   = feat_on & feat_act_r[7-FB_PWRDN];
    wire f_cld   = feat_on & feat_act_r[7-FB_CNT_LOAD];
    wire f_modulus_control  = feat_on & feat_act_r[7-FB_MOD_MON];
    wire f_rmon  = feat_on & feat_act_r[7-FB_REF_MON];
    wire f_lddis = feat_on & feat_act_r[7-FB_LD_DIS];
    //----------------------------------------------------------------
    // main chain: prescaler, swallow and main counters
    //----------------------------------------------------------------
    logic [3:0]        pre_cnt_r;  // prescaler phase
    logic [SWAL_W-1:0] swal_cnt_r; // swallow count
    logic [MAIN_W-1:0] main_cnt_r; // main count
    logic              fp_r;       // divided rf pulse
    wire [3:0] pre_base = sel56_s ? PRE_LO5 : PRE_LO10;
    wire       mod_hi   = ~pre_off & (swal_cnt_r != '0);
    wire [3:0] pre_top  = mod_hi ? pre_base : pre_base - 4'h1;
    wire pre_tick = pre_off ? rf_rise :
                    rf_rise & (pre_cnt_r == pre_top);
    wire main_end = pre_tick & (main_cnt_r == '0);
    wire reload   = main_end | f_cld;
    // ratio: base*(main+1)+swallow, or main+1 when bypassed
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt_r  <= 4'h0;
            swal_cnt_r <= '0;
            main_cnt_r <= '0;
            fp_r       <= 1'b0;
        end else if (f_pdn) begin
            fp_r <= 1'b0;
        end else begin
            fp_r <= main_end;
            if (rf_rise)
                pre_cnt_r <= (pre_tick | pre_off) ? 4'h0
                                                  : pre_cnt_r + 4'h1;
            if (reload) begin
                main_cnt_r <= main_v;
                swal_cnt_r <= pre_off ? '0 : swal_v;
            end else if (pre_tick) begin
                main_cnt_r <= main_cnt_r - 9'h001;
                if (swal_cnt_r != '0)
                    swal_cnt_r <= swal_cnt_r - 4'h1;
            end
        end
    end
    //----------------------------------------------------------------
    // reference counter
    //----------------------------------------------------------------
    logic [REF_W-1:0] ref_cnt_r;  // edges left before the fc pulse
    logic             fc_r;       // divided reference pulse
    wire ref_end = ref_rise & (ref_cnt_r == '0);
    // reload at zero, so r plus one input edges per output pulse
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_cnt_r <= '0;
            fc_r      <= 1'b0;
        end else if (f_pdn) begin
            fc_r <= 1'b0;
        end else begin
            fc_r <= ref_end;
            if (ref_rise)
                ref_cnt_r <= (ref_cnt_r == '0) ? ref_v
                                               : ref_cnt_r - 6'h01;
        end
    end
    //----------------------------------------------------------------
    // phase frequency detector, pulses only (edge events)
    //----------------------------------------------------------------
    logic up_r, dn_r;   // active high internal pump states
    wire up_nxt = ~f_pdn & (up_r | fc_r) & ~((dn_r | fp_r) & (up_r | fc_r));
    wire dn_nxt = ~f_pdn & (dn_r | fp_r) & ~((dn_r | fp_r) & (up_r | fc_r));
    // both set means both arrived: clear at once, no dead band
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end else begin
            up_r <= up_nxt;
            dn_r <= dn_nxt;
        end
    end
    //----------------------------------------------------------------
    // outputs, all registered
    //----------------------------------------------------------------
    // monitor source priority: main, modulus, reference
    wire mon_nxt = f_mmon ? fp_r : f_modulus_control ? mod_hi : f_rmon ? fc_r : 1'b0;
    // every pin straight from a flip-flop; monitor and modulus pins lag one cycle, pump and lock pins take next state, no lag
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pump_up_n_o       <= 1'b1;
            pump_down_n_o     <= 1'b1;
            lock_filter_o     <= 1'b0;
            lock_indicator_o  <= 1'b1;
            monitor_o         <= 1'b0;
            modulus_control_o <= 1'b0;
        end else begin
            pump_up_n_o       <= ~up_nxt;
            pump_down_n_o     <= ~dn_nxt;
            lock_filter_o     <= ~(~up_nxt & ~dn_nxt);
            lock_indicator_o  <= f_lddis | (~up_nxt & ~dn_nxt);
            monitor_o         <= mon_nxt;
            modulus_control_o <= mod_hi;
        end
    end
endmodule

/* design/pll_ctrl_pkg.sv */
// constants and types shared by the synthesizer core and its programmer
// Summary of operation
// - locked rf equals fc times modulus-scaled main count
// - main count minimum one gives ratio two
// - swallow count accepts up to fifteen
// - controller keeps rf at least 90/20 fc
// - prescaler enable high bypasses prescaler and swallow
// - reference divides by r plus one
// - 21 bits shift msb first into setting
// - load strobe rise copies setting to counters; code copies it to set_act_r, which the counters take at their next reload
// - eight bits shift into feature shift register
// - feature buffer captured on select falling edge
// - feature bits act only while enable low
// - parallel select takes settings from pins
// - setting bit order as documented
// - reserved feature bits written zero
// - bits 2,5,6 route signals to monitor
// - bit 3 powers down all but programming
// - bit 4 loads counters immediately and continuously
// - bit 7 disables lock indicator
// - phase detector acts on rising edges only
// - rf leading pulses pump down low
// - reference leading pulses pump up low
// - lock filter nand, lock indicator and
// - prescaler divides five/six or ten/eleven
package pll_ctrl_pkg;
    //----------------------------------------------------------------
    // register widths
    //----------------------------------------------------------------
    localparam int SET_W  = 21;   // divider setting register width
    localparam int FEAT_W = 8;    // feature control register width
    localparam int MAIN_W = 9;    // main counter width
    localparam int SWAL_W = 4;    // swallow counter width
    localparam int REF_W  = 6;    // reference counter width
    //----------------------------------------------------------------
    // feature control bit positions (msb-first index b0..b7)
    //----------------------------------------------------------------
    localparam int FB_MAIN_MON = 2;   // main counter to monitor
    localparam int FB_PWRDN    = 3;   // power down
    localparam int FB_CNT_LOAD = 4;   // immediate counter load
    localparam int FB_MOD_MON  = 5;   // modulus control to monitor
    localparam int FB_REF_MON  = 6;   // reference counter to monitor
    localparam int FB_LD_DIS   = 7;   // lock indicator disable
    //----------------------------------------------------------------
    // prescaler base ratios
    //----------------------------------------------------------------
    localparam logic [3:0] PRE_LO5  = 4'h5;  // 5/6 base
    localparam logic [3:0] PRE_LO10 = 4'hA;  // 10/11 base
    //----------------------------------------------------------------
    // programmer host register map (apb word offsets)
    //----------------------------------------------------------------
    localparam logic [7:0] A_SET    = 8'h00; // setting word to send
    localparam logic [7:0] A_FEAT   = 8'h04; // feature word to send
    localparam logic [7:0] A_CTRL   = 8'h08; // go bits
    localparam logic [7:0] A_STAT   = 8'h0C; // busy
    localparam logic [7:0] A_PINS   = 8'h10; // mode pins
    localparam int CB_GO_SET  = 0;        // start setting load
    localparam int CB_GO_FEAT = 1;        // start feature load
    localparam logic [3:0] SCK_DIV = 4'h4; // divider top: tick every 5 mclk cycles, sck high 5, low 10
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_LOW   = 3'b001,
        H_HIGH  = 3'b010,
        H_STRB  = 3'b011,
        H_DONE  = 3'b100
    } host_st_t;
endpackage

/* design/pll_prog_host.sv */
// apb-driven programmer that drives the three-wire port
`timescale 1ns/1ps
module pll_prog_host
    import pll_ctrl_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    pll_prog_if.host         prog
);
    logic [SET_W-1:0]  set_r;    // word to send, b0 first
    logic [FEAT_W-1:0] feat_r;   // feature word
    logic [23:0]       pins_r;   // [22:2] par pins,1 par sel,0 fen_n
    host_st_t          st_r;
    logic [4:0]        bit_r;    // bits left
    logic              feat_m_r; // sending feature word
    logic [3:0]        div_r;    // sequencer tick divider, one tick per sck high phase
    logic [SET_W-1:0]  sh_r;     // outgoing shift
    logic              sck_r, sdo_r, strb_r, fws_r;
    //----------------------------------------------------------------
    // apb decode, zero wait
    //----------------------------------------------------------------
    wire acc   = psel_i & penable_i;
    wire wr    = acc & pwrite_i;
    wire hit   = paddr_i inside {A_SET, A_FEAT, A_CTRL, A_STAT, A_PINS};
    wire busy  = (st_r != H_IDLE);
    wire go_s  = wr & (paddr_i == A_CTRL) & pwdata_i[CB_GO_SET] & ~busy;
    wire go_f  = wr & (paddr_i == A_CTRL) & pwdata_i[CB_GO_FEAT] & ~busy
                 & ~pwdata_i[CB_GO_SET];
    wire tick  = (div_r == SCK_DIV);
    wire [31:0] rd_w = (paddr_i == A_SET)  ? {11'h000, set_r} :
                       (paddr_i == A_FEAT) ? {24'h000000, feat_r} :
                       (paddr_i == A_STAT) ? {31'h00000000, busy} :
                       (paddr_i == A_PINS) ? {8'h00, pins_r} : 32'h00000000;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            set_r  <= '0;
            feat_r <= '0;
            pins_r <= 24'h000001;  // features off by default
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
        end else begin
            if (wr & (paddr_i == A_SET))  set_r  <= pwdata_i[SET_W-1:0];
            if (wr & (paddr_i == A_FEAT)) feat_r <= pwdata_i[FEAT_W-1:0];
            if (wr & (paddr_i == A_PINS)) pins_r <= pwdata_i[23:0];
            prdata_o  <= rd_w;
            pready_o  <= 1'b1;
            pslverr_o <= psel_i & ~penable_i & ~hit;  // unmapped word
        end
    end
    //----------------------------------------------------------------
    // shift sequencer: data set while clock low, msb first
    //----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= H_IDLE; bit_r <= 5'h00; feat_m_r <= 1'b0;
            div_r <= 4'h0; sh_r <= '0;
            sck_r <= 1'b0; sdo_r <= 1'b0; strb_r <= 1'b0; fws_r <= 1'b0;
        end else begin
            div_r <= (busy & ~tick) ? div_r + 4'h1 : 4'h0;
            unique case (st_r)
                H_IDLE: begin
                    strb_r <= 1'b0;
                    if (go_s | go_f) begin
                        feat_m_r <= go_f;
                        fws_r    <= go_f;
                        sh_r     <= go_f ? {feat_r, 13'h0000} : set_r;
                        bit_r    <= go_f ? 5'h08 : 5'h15;
                        st_r     <= H_LOW;
                    end
                end
                H_LOW: if (tick) begin
                    sdo_r <= sh_r[SET_W-1];
                    sh_r  <= {sh_r[SET_W-2:0], 1'b0};
                    st_r  <= H_HIGH;
                end
                H_HIGH: if (tick) begin
                    sck_r <= ~sck_r;
                    if (sck_r) begin
                        bit_r <= bit_r - 5'h01;
                        st_r  <= (bit_r == 5'h01) ? H_STRB : H_LOW;
                    end
                end
                H_STRB: if (tick) begin
                    if (feat_m_r) fws_r <= 1'b0;
                    else strb_r <= 1'b1;
                    st_r <= H_DONE;
                end
                H_DONE: if (tick) begin
                    strb_r <= 1'b0;
                    st_r   <= H_IDLE;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end
    assign prog.shift_clk        = sck_r;
    assign prog.serial_bit_in    = sdo_r;
    assign prog.load_strobe      = strb_r;
    assign prog.feat_wr_sel      = fws_r;
    assign prog.feature_enable_n = pins_r[0];
    assign prog.parallel_sel     = pins_r[1];
    assign prog.par_setting      = pins_r[22:2];
endmodule

/* design/pll_prog_if.sv */
// three-wire programming link plus parallel pins between host and device
`timescale 1ns/1ps
interface pll_prog_if;
    logic       shift_clk;         // serial shift clock
    logic       serial_bit_in;     // serial data
    logic       load_strobe;       // setting load strobe
    logic       feat_wr_sel;       // feature write select
    logic       feature_enable_n;  // feature bits active low enable
    logic       parallel_sel;      // parallel settings select
    logic [20:0] par_setting;      // parallel setting pins, b0 at bit 20
    modport host (output shift_clk, serial_bit_in, load_strobe,
                  feat_wr_sel, feature_enable_n, parallel_sel,
                  par_setting);
    modport dev  (input shift_clk, serial_bit_in, load_strobe,
                  feat_wr_sel, feature_enable_n, parallel_sel,
                  par_setting);
endinterface

/* design/sync2.sv */
// two flip-flop synchroniser for one bit
`timescale 1ns/1ps
module sync2 (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;   // first stage, read only by second
    //----------------------------------------------------------------
    // two stages
    //----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

/* tb/integer_pll_divider_control_tb.sv */
// self-checking bench joining programmer and synthesizer core
`timescale 1ns/1ps
module integer_pll_divider_control_tb
    import pll_ctrl_pkg::*;
;
    logic        mclk_i = 1'b0, rst_i = 1'b1;      // clock, reset
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, slv, pu, pd, lf, li, mon, mc;
    logic        rf = 1'b0, rfr = 1'b0, pre56 = 1'b0;  // core inputs
    logic [2:0]  rc = 3'h0;                          // rf phase
    logic [3:0]  fc = 4'h0;                          // ref phase
    int          err_total = 0, compares = 0, nu, nd, nl, nm, nf, nc;
    always #5 mclk_i = ~mclk_i;
    // rf period 8 cycles, ref period 10, both under mclk/4
    always @(posedge mclk_i) begin
        rc  <= rc + 3'h1;
        fc  <= (fc == 4'h9) ? 4'h0 : fc + 4'h1;
        rf  <= rc[2];
        rfr <= (fc > 4'h4);
    end
    pll_prog_if u_pll_prog_if ();
    pll_prog_host u_pll_prog_host (.mclk_i(mclk_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .prog(u_pll_prog_if));
    pll_core u_pll_core (.mclk_i(mclk_i), .rst_i(rst_i),
        .prog(u_pll_prog_if), .rf_in_i(rf), .ref_in_i(rfr),
        .pre_sel56_i(pre56), .pump_up_n_o(pu), .pump_down_n_o(pd),
        .lock_filter_o(lf), .lock_indicator_o(li), .monitor_o(mon),
        .modulus_control_o(mc));
    pll_link_chk u_pll_link_chk (.mclk_i(mclk_i), .rst_i(rst_i),
        .shift_clk(u_pll_prog_if.shift_clk),
        .serial_bit_in(u_pll_prog_if.serial_bit_in),
        .load_strobe(u_pll_prog_if.load_strobe),
        .feat_wr_sel(u_pll_prog_if.feat_wr_sel));
    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_int(input int got, input int exp);
        compares++;
        if (got != exp) begin
            err_total++;
            $display("wrong value at %0t: %0d not %0d", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: flag %b", $time, got);
        end
    endtask
    // one apb transfer; pready, prdata and pslverr taken at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1) @(posedge mclk_i);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // load a word and start its frame, then poll busy
    task automatic prog(input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] go);
        logic [31:0] q;
        apb(1'b1, a, d, q);
        apb(1'b1, A_CTRL, go, q);
        do apb(1'b0, A_STAT, 32'h0, q); while (q[0] !== 1'b0);
    endtask
    // cycles between the second and third monitor rises
    task automatic per(output int n);
        int   i;
        logic p;
        i = 0;
        n = 0;
        p = mon;
        while (i < 3 && n < 4000) begin
            @(negedge mclk_i);
            n++;
            if (mon === 1'b1 && p === 1'b0) i++;
            if (mon === 1'b1 && p === 1'b0 && i < 3) n = 0;
            p = mon;
        end
    endtask
    // counts pump, lock-low and monitor-change cycles
    task automatic watch(input int n);
        logic p;
        nu = 0;
        nd = 0;
        nl = 0;
        nm = 0;
        nf = 0;
        nc = 0;
        p = mon;
        repeat (n) begin
            @(negedge mclk_i);
            nu += (pu !== 1'b1);
            nd += (pd !== 1'b1);
            nl += (li !== 1'b1);
            nm += (mon !== p);
            nf += (lf !== ~(pu & pd));
            nc += (mc !== 1'b0);
            p = mon;
        end
    endtask
    // setting word, b0 at the top, address bit zero
    function automatic logic [20:0] sw(input logic [8:0] m,
        input logic [5:0] r, input logic [3:0] a, input logic pe);
        return {r[5:4], m[8:7], pe, m[6:0], r[3:0], a, 1'b0};
    endfunction
    function automatic int main_exp(input int m, a, md);
        if (md == 0) return (m + 1) * 8;
        return ((md == 1 ? 10 : 5) * (m + 1) + a) * 8;
    endfunction
    initial begin
        repeat (40000) @(posedge mclk_i);
        err_total++;
        give_verdict();
    end
    initial begin
        int i, m, a, r, md, n;
        logic [31:0] q, pw;
        i = $urandom(32'h4DE4);
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        apb(1'b0, 8'h40, 32'h0, q);
        chk_bit(slv, 1'b1);
        apb(1'b1, A_PINS, 32'h0, q);
        for (i = 0; i < 4; i++) begin
            m  = (i == 0) ? 1 : (i == 3) ? 14 : 1 + $urandom % 4;
            r  = (i == 0) ? 0 : $urandom % 8;
            md = (i == 0) ? 0 : (i == 3) ? 1 : 1 + $urandom % 2;
            a  = (i == 3) ? 15 : $urandom % (m + 2);
            @(posedge mclk_i);
            pre56 <= (md == 2);
            prog(A_SET, {11'h0, sw(m[8:0], r[5:0], a[3:0], md == 0)}, 1);
            prog(A_FEAT, 32'h20, 32'h2);
            per(n);
            chk_int(n, main_exp(m, a, md));
            prog(A_FEAT, 32'h02, 32'h2);
            per(n);
            chk_int(n, (r + 1) * 10);
        end
        apb(1'b1, A_PINS, 32'h1, q);
        prog(A_FEAT, 32'h20, 32'h2);
        watch(600);
        chk_int(nm, 0);
        apb(1'b1, A_PINS, 32'h0, q);
        prog(A_FEAT, 32'h30, 32'h2);
        watch(600);
        chk_int(nm, 0);
        prog(A_FEAT, 32'h0, 32'h2);
        pw = {9'h0, sw(9'h1, 6'h7, 4'h2, 1'b1), 2'b11};
        apb(1'b1, A_PINS, pw, q);
        apb(1'b0, A_PINS, 32'h0, q);
        chk_bit(q === pw, 1'b1);
        watch(500);
        watch(1500);
        chk_bit(nd > 4 * nu, 1'b1);
        chk_bit(nl > 0, 1'b1);
        chk_int(nf, 0);
        chk_int(nc, 0);
        apb(1'b1, A_PINS, 32'h0, q);
        prog(A_SET, {11'h0, sw(9'h14, 6'h0, 4'h0, 1'b1)}, 32'h1);
        watch(500);
        watch(1500);
        chk_bit(nu > 4 * nd, 1'b1);
        prog(A_FEAT, 32'h01, 32'h2);
        watch(1000);
        chk_int(nl, 0);
        give_verdict();
    end
endmodule

/* tb/pll_link_chk.sv */
// wire-level checker for the three-wire programming link
`timescale 1ns/1ps
module pll_link_chk (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic shift_clk,
    input  wire logic serial_bit_in,
    input  wire logic load_strobe,
    input  wire logic feat_wr_sel
);
    logic [4:0] bit_cnt_r;  // shift edges since last frame end
    logic       sck_d_r;    // shift clock, one cycle late
    logic       sel_d_r;    // feature select, one cycle late
    // bit counter, cleared by strobe or select fall
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_r <= 5'h00;
            sck_d_r   <= 1'b0;
            sel_d_r   <= 1'b0;
        end else begin
            sck_d_r <= shift_clk;
            sel_d_r <= feat_wr_sel;
            if (load_strobe || (sel_d_r && !feat_wr_sel)) begin
                bit_cnt_r <= 5'h00;
            end else if (shift_clk && !sck_d_r) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_SCK_HIGH: assert property ($rose(shift_clk) |->
        shift_clk [*5] ##1 !shift_clk) else $error("bad sck high");
    AST_SCK_LOW: assert property ($fell(shift_clk) |->
        !shift_clk [*5]) else $error("bad sck low");
    AST_DATA_HOLD: assert property (shift_clk |->
        $stable(serial_bit_in)) else $error("data moved, sck high");
    AST_STRB_IDLE: assert property (load_strobe |->
        !shift_clk && !feat_wr_sel) else $error("strobe overlap");
    AST_SET_COUNT: assert property ($rose(load_strobe) |->
        bit_cnt_r == 5'h15) else $error("setting frame length");
    AST_FEAT_COUNT: assert property ($fell(feat_wr_sel) |->
        bit_cnt_r == 5'h08) else $error("feature frame length");
    AST_FEAT_FALL: assert property ($fell(feat_wr_sel) |->
        !shift_clk) else $error("select fell, sck high");
    AST_CNT_MAX: assert property (bit_cnt_r <= 5'h15)
        else $error("frame too long");
    COV_SET: cover property ($rose(load_strobe));
    COV_FEAT: cover property ($fell(feat_wr_sel));
    COV_FBIT: cover property ($rose(shift_clk) && feat_wr_sel);
endmodule
